//--- hw/rtp_core.sv
// Overview of operation
// - Weekday counts Sunday 00 to Saturday 06.
// - 12-hour alarm hour is BCD, bit5 afternoon.
// - 24-hour alarm hour is plain BCD 00-23.
// - Prescaler mode register resets 00H, enable gates.
// - Source select divides main clock by 1,2,4,8.
// - Count clock is source over 2N, 00H means 256.
// - Wait request halts seconds through years.
// - Wait status rises once counters are frozen.
// - One subsecond carry kept while frozen.
// - Clearing wait request resumes counting.
// - Counters accessible in any order, subsets allowed.
// - Interrupt setting changes may glitch outputs.
// - Weekday mask bits enable alarm per day.
// - Alarm minute BCD 00-59, else never matches.
// - 12-hour alarm hour bit5: 0 morning, 1 afternoon.
`timescale 1ns/1ps
`default_nettype none
module rtp_core (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             countClockTick,
  output logic             alarmMatch
);

  logic [7:0]  prescalerMode_reg;
  logic [7:0]  prescalerCompare_reg;
  logic [2:0]  preDiv_reg;
  logic [7:0]  halfCount_reg;
  logic        countClock_reg;
  logic [15:0] subsecTop_reg;
  logic [15:0] subsec_reg;
  logic        waitRequest_reg;
  logic        waitStatus_reg;
  logic        carryPending_reg;
  logic        hourFormat_reg;
  rtp_pkg::rtp_time_t timeNow_reg;
  logic [7:0]  day_reg;
  logic [7:0]  month_reg;
  logic [7:0]  year_reg;
  rtp_pkg::rtp_alarm_t alarm_reg;
  logic        alarmHit_reg;

  logic        regWrite;
  logic        accessPhase;
  logic [27:0] wordIndex;
  logic        mapped;
  logic        countEnable;
  logic        srcTick;
  logic        fbrgRise;
  logic        subsecCarry;
  logic        secondStep;
  logic [2:0]  divMask;

  assign accessPhase = psel && penable;
  assign regWrite    = accessPhase && pwrite;
  assign wordIndex   = paddr[29:2];
  assign countEnable = prescalerMode_reg[rtp_pkg::CCE_BIT];

  always_comb
  begin
    case (wordIndex)
      rtp_pkg::IDX_PRESCALER_MODE, rtp_pkg::IDX_PRESCALER_COMPARE, rtp_pkg::IDX_COUNTER_CONTROL,
      rtp_pkg::IDX_CAL_TIME, rtp_pkg::IDX_CAL_DATE, rtp_pkg::IDX_ALARM,
      rtp_pkg::IDX_SUBSEC_TOP: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // BCD increment with wrap to a given value at a given limit.
  function automatic logic [7:0] bcdStep(input logic [7:0] v, input logic [7:0] lim, input logic [7:0] wrapTo);
    if (v >= lim)
      bcdStep = wrapTo;
    else if (v[3:0] == 4'h9)
      bcdStep = {v[7:4] + 4'h1, 4'h0};
    else
      bcdStep = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Valid BCD byte not above a limit.
  function automatic logic bcdOk(input logic [7:0] v, input logic [7:0] lim);
    bcdOk = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v <= lim);
  endfunction

  // Register writes.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prescalerMode_reg    <= rtp_pkg::PRESCALER_MODE_RST;
      prescalerCompare_reg <= rtp_pkg::PRESCALER_COMPARE_RST;
      waitRequest_reg      <= 1'b0;
      hourFormat_reg       <= 1'b0;
      alarm_reg            <= '0;
      subsecTop_reg        <= rtp_pkg::SUBSEC_TOP_RST;
    end
    else if (regWrite)
    begin
      case (wordIndex)
        rtp_pkg::IDX_PRESCALER_MODE:    prescalerMode_reg    <= pwdata[7:0] & 8'h13;
        rtp_pkg::IDX_PRESCALER_COMPARE: prescalerCompare_reg <= pwdata[7:0];
        rtp_pkg::IDX_COUNTER_CONTROL:
        begin
          waitRequest_reg <= pwdata[0];
          hourFormat_reg  <= pwdata[rtp_pkg::HFS_BIT];
        end
        rtp_pkg::IDX_ALARM:             alarm_reg            <= pwdata[22:0];
        rtp_pkg::IDX_SUBSEC_TOP:        subsecTop_reg        <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Source divider and the 2N count-clock divider.
  always_comb
  begin
    case (prescalerMode_reg[1:0])
      2'b00:   divMask = 3'h0;
      2'b01:   divMask = 3'h1;
      2'b10:   divMask = 3'h3;
      default: divMask = 3'h7;
    endcase
  end
  assign srcTick = countEnable && ((preDiv_reg & divMask) == divMask);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      preDiv_reg <= 3'h0;
    else if (!countEnable)
      preDiv_reg <= 3'h0;
    else
      preDiv_reg <= preDiv_reg + 3'h1;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      halfCount_reg  <= 8'h00;
      countClock_reg <= 1'b0;
    end
    else if (!countEnable)
    begin
      halfCount_reg  <= 8'h00;
      countClock_reg <= 1'b0;
    end
    else if (srcTick)
    begin
      // Compare of 00H wraps after 256 source ticks per half period.
      if (halfCount_reg == prescalerCompare_reg - 8'h01)
      begin
        halfCount_reg  <= 8'h00;
        countClock_reg <= ~countClock_reg;
      end
      else
        halfCount_reg <= halfCount_reg + 8'h01;
    end
  end
  assign fbrgRise = srcTick && !countClock_reg && (halfCount_reg == prescalerCompare_reg - 8'h01);

  // Subsecond counter; carry into seconds.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      subsec_reg <= 16'h0000;
    else if (fbrgRise)
      subsec_reg <= (subsec_reg >= subsecTop_reg) ? 16'h0000 : subsec_reg + 16'h0001;
  end
  assign subsecCarry = fbrgRise && (subsec_reg >= subsecTop_reg);

  // Wait handshake and the single retained carry.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      waitStatus_reg   <= 1'b0;
      carryPending_reg <= 1'b0;
    end
    else
    begin
      waitStatus_reg <= waitRequest_reg;
      if (waitStatus_reg && subsecCarry)
        carryPending_reg <= 1'b1;
      else if (!waitStatus_reg)
        carryPending_reg <= 1'b0;
    end
  end
  assign secondStep = !waitStatus_reg && (subsecCarry || carryPending_reg);

  // Calendar counters; writable only through the bus while frozen is advised.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      timeNow_reg <= '0;
      day_reg     <= rtp_pkg::DAY_RST;
      month_reg   <= rtp_pkg::MONTH_RST;
      year_reg    <= 8'h00;
    end
    else if (regWrite && wordIndex == rtp_pkg::IDX_CAL_TIME)
      timeNow_reg <= pwdata[26:0];
    else if (regWrite && wordIndex == rtp_pkg::IDX_CAL_DATE)
    begin
      day_reg   <= pwdata[7:0];
      month_reg <= pwdata[15:8];
      year_reg  <= pwdata[23:16];
    end
    else if (secondStep)
    begin
      timeNow_reg.second <= bcdStep(timeNow_reg.second, 8'h59, 8'h00);
      if (timeNow_reg.second == 8'h59)
      begin
        timeNow_reg.minute <= bcdStep(timeNow_reg.minute, 8'h59, 8'h00);
        if (timeNow_reg.minute == 8'h59)
        begin
          if (hourFormat_reg)
            timeNow_reg.hour <= bcdStep(timeNow_reg.hour, 8'h23, 8'h00);
          else if (timeNow_reg.hour == 8'h11)
            timeNow_reg.hour <= 8'h32;
          else if (timeNow_reg.hour == 8'h31)
            timeNow_reg.hour <= 8'h12;
          else if (timeNow_reg.hour == 8'h12)
            timeNow_reg.hour <= 8'h01;
          else if (timeNow_reg.hour == 8'h32)
            timeNow_reg.hour <= 8'h21;
          else
            timeNow_reg.hour <= {timeNow_reg.hour[7:4], 4'h0} | bcdStep({4'h0, timeNow_reg.hour[3:0]}, 8'h09, 8'h10);
          if ((hourFormat_reg && timeNow_reg.hour == 8'h23) || (!hourFormat_reg && timeNow_reg.hour == 8'h31))
          begin
            timeNow_reg.weekday <= (timeNow_reg.weekday >= rtp_pkg::WEEK_SAT) ? 3'h0
                                   : timeNow_reg.weekday + 3'h1;
            day_reg <= bcdStep(day_reg, 8'h31, 8'h01);
            if (day_reg == 8'h31)
            begin
              month_reg <= bcdStep(month_reg, 8'h12, 8'h01);
              if (month_reg == 8'h12)
                year_reg <= bcdStep(year_reg, 8'h99, 8'h00);
            end
          end
        end
      end
    end
  end

  // Alarm compare: 24h plain BCD, 12h BCD with afternoon flag.
  logic hourValid;
  always_comb
  begin
    if (hourFormat_reg)
      hourValid = bcdOk(alarm_reg.hour, 8'h23);
    else
      hourValid = bcdOk({3'h0, alarm_reg.hour[4:0]}, 8'h12) && alarm_reg.hour[4:0] != 5'h00
                  && alarm_reg.hour[7:6] == 2'b00;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      alarmHit_reg <= 1'b0;
    else
      // A weekday code above Saturday never matches.
      alarmHit_reg <= (timeNow_reg.weekday <= rtp_pkg::WEEK_SAT) && alarm_reg.weekdayMask[timeNow_reg.weekday]
                      && hourValid && bcdOk(alarm_reg.minute, 8'h59)
                      && timeNow_reg.hour == alarm_reg.hour && timeNow_reg.minute == alarm_reg.minute;
  end

  // APB answer, zero wait states.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (wordIndex)
          rtp_pkg::IDX_PRESCALER_MODE:    prdata <= {24'h0, prescalerMode_reg};
          rtp_pkg::IDX_PRESCALER_COMPARE: prdata <= {24'h0, prescalerCompare_reg};
          rtp_pkg::IDX_COUNTER_CONTROL:   prdata <= {28'h0, hourFormat_reg, 1'b0, waitStatus_reg, waitRequest_reg};
          rtp_pkg::IDX_CAL_TIME:          prdata <= {5'h0, timeNow_reg};
          rtp_pkg::IDX_CAL_DATE:          prdata <= {8'h0, year_reg, month_reg, day_reg};
          rtp_pkg::IDX_ALARM:             prdata <= {9'h0, alarm_reg};
          rtp_pkg::IDX_SUBSEC_TOP:        prdata <= {16'h0, subsecTop_reg};
          default:                        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      countClockTick <= 1'b0;
      alarmMatch     <= 1'b0;
    end
    else
    begin
      countClockTick <= fbrgRise;
      // Delayed one more cycle after alarmHit_reg; a setting change can still glitch the alarm output.
      alarmMatch     <= alarmHit_reg;
    end
  end

  AST_ENABLE_GATES: assert property (@(posedge sys_clk) disable iff (reset)
    !countEnable |=> !countClockTick) else $error("count clock ticked while disabled");
  AST_WAIT_STATUS: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(waitRequest_reg) |=> waitStatus_reg) else $error("wait status late");
  AST_FROZEN: assert property (@(posedge sys_clk) disable iff (reset)
    waitStatus_reg && !regWrite |=> $stable(timeNow_reg)) else $error("counters moved while frozen");
  AST_CARRY_KEPT: assert property (@(posedge sys_clk) disable iff (reset)
    waitStatus_reg && subsecCarry |=> carryPending_reg) else $error("carry lost");
  AST_RESUME: assert property (@(posedge sys_clk) disable iff (reset)
    !waitStatus_reg && carryPending_reg && !regWrite |=> timeNow_reg.second != $past(timeNow_reg.second))
    else $error("pending carry not applied");
  AST_WEEK_RANGE: assert property (@(posedge sys_clk) disable iff (reset)
    secondStep && timeNow_reg.weekday == 3'h6 && timeNow_reg.second == 8'h59 && timeNow_reg.minute == 8'h59
    && timeNow_reg.hour == 8'h23 && hourFormat_reg && !regWrite |=> timeNow_reg.weekday == 3'h0)
    else $error("weekday did not wrap to Sunday");
  AST_MINUTE_RANGE: assert property (@(posedge sys_clk) disable iff (reset)
    !bcdOk(alarm_reg.minute, 8'h59) |=> !alarmHit_reg) else $error("bad minute matched");
  AST_MASK: assert property (@(posedge sys_clk) disable iff (reset)
    !alarm_reg.weekdayMask[timeNow_reg.weekday] |=> ##1 !alarmMatch)
    else $error("masked day raised alarm");
  COV_WAIT: cover property (@(posedge sys_clk) disable iff (reset) $rose(waitStatus_reg));
  COV_CARRY: cover property (@(posedge sys_clk) disable iff (reset) waitStatus_reg && subsecCarry);
  COV_ALARM: cover property (@(posedge sys_clk) disable iff (reset) $rose(alarmMatch));

endmodule // rtp_core
`default_nettype wire

//--- hw/rtp_pkg.sv
package rtp_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [27:0] IDX_PRESCALER_MODE    = 28'hFFFF8B0;
  localparam logic [27:0] IDX_PRESCALER_COMPARE = 28'hFFFF8B1;
  localparam logic [27:0] IDX_COUNTER_CONTROL   = 28'hFFFF8B2;
  localparam logic [27:0] IDX_CAL_TIME          = 28'hFFFF8B3;
  localparam logic [27:0] IDX_CAL_DATE          = 28'hFFFF8B4;
  localparam logic [27:0] IDX_ALARM             = 28'hFFFF8B5;
  localparam logic [27:0] IDX_SUBSEC_TOP        = 28'hFFFF8B6;

  localparam logic [7:0]  PRESCALER_MODE_RST    = 8'h00;
  localparam logic [7:0]  PRESCALER_COMPARE_RST = 8'h00;
  localparam int          CCE_BIT               = 4;
  localparam int          HFS_BIT               = 3;
  localparam int          PM_BIT                = 5;
  localparam logic [2:0]  WEEK_SAT              = 3'h6;
  localparam logic [15:0] SUBSEC_TOP_RST        = 16'h7FFF;
  localparam logic [7:0]  DAY_RST               = 8'h01;
  localparam logic [7:0]  MONTH_RST             = 8'h01;

  typedef struct packed {
    logic [6:0] weekdayMask;
    logic [7:0] hour;
    logic [7:0] minute;
  } rtp_alarm_t;

  typedef struct packed {
    logic [7:0] second;
    logic [7:0] minute;
    logic [7:0] hour;
    logic [2:0] weekday;
  } rtp_time_t;

endpackage

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sysClk         = 1'b0;
  logic        reset          = 1'b1;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [31:0] paddr          = 32'h0;
  logic [31:0] pwdata         = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick;
  logic        alarm;
  logic [31:0] rd;
  logic        err;
  logic [31:0] lfsr           = 32'hA963;
  logic [7:0]  s0;
  int          badCount       = 0;
  int          samplesChecked = 0;
  int          cycles         = 0;
  int          n;

  always #2.5 sysClk = ~sysClk;

  rtp_core dut (
    .sys_clk        (sysClk),
    .reset          (reset),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .countClockTick (tick),
    .alarmMatch     (alarm)
  );

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge sysClk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      badCount++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [27:0] idx, input logic [31:0] wd);
    @(posedge sysClk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'b00};
    pwdata  <= wd;
    @(posedge sysClk);
    penable <= 1'b1;
    do
      @(posedge sysClk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts main clock cycles between two successive count clock pulses.
  task automatic measure(input int expPer);
    int k;
    k = 0;
    do @(posedge sysClk); while (tick !== 1'b1 && ++k < 9000);
    k = 0;
    do @(posedge sysClk); while (tick !== 1'b1 && ++k < 9000);
    check(k + 1, expPer);
  endtask

  task automatic alarmCase(input logic h24, input logic [2:0] w, input logic [7:0] th, input logic [7:0] tm,
                           input logic [6:0] m, input logic [7:0] ah, input logic [7:0] am);
    logic e;
    e = m[w] && th == ah && tm == am && am[7:4] < 4'h6 && am[3:0] < 4'hA && ah[3:0] < 4'hA
        && (h24 ? ah <= 8'h23 : ((ah >= 8'h01 && ah <= 8'h12) || (ah >= 8'h21 && ah <= 8'h32)));
    apb(1'b1, rtp_pkg::IDX_COUNTER_CONTROL, {28'h0, h24, 3'b000});
    apb(1'b1, rtp_pkg::IDX_CAL_TIME, {13'h0, tm, th, w});
    apb(1'b1, rtp_pkg::IDX_ALARM, {9'h0, m, ah, am});
    repeat (3) @(posedge sysClk);
    check({31'h0, alarm}, {31'h0, e});
  endtask

  initial
  begin
    repeat (20) @(posedge sysClk);
    reset <= 1'b0;
    apb(1'b0, rtp_pkg::IDX_PRESCALER_MODE, 32'h0);
    check(rd, {24'h0, rtp_pkg::PRESCALER_MODE_RST});
    apb(1'b0, rtp_pkg::IDX_PRESCALER_COMPARE, 32'h0);
    check(rd, {24'h0, rtp_pkg::PRESCALER_COMPARE_RST});
    apb(1'b0, rtp_pkg::IDX_SUBSEC_TOP, 32'h0);
    check(rd, {16'h0, rtp_pkg::SUBSEC_TOP_RST});
    apb(1'b0, 28'hFFFF8B7, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    n = 0;
    repeat (600) @(posedge sysClk) n += (tick === 1'b1);
    check(n, 0);
    for (int ss = 0; ss < 4; ss++)
    begin
      s0 = (ss == 0) ? 8'h00 : rnd();
      apb(1'b1, rtp_pkg::IDX_PRESCALER_MODE, ss);
      apb(1'b1, rtp_pkg::IDX_PRESCALER_COMPARE, {24'h0, s0});
      apb(1'b1, rtp_pkg::IDX_PRESCALER_MODE, 32'h10 | ss);
      measure((1 << ss) * 2 * ((s0 == 8'h00) ? 256 : int'(s0)));
      apb(1'b0, rtp_pkg::IDX_PRESCALER_MODE, 32'h0);
      check(rd, 32'h10 | ss);
      apb(1'b1, rtp_pkg::IDX_PRESCALER_MODE, ss);
    end
    for (int w = 0; w < 7; w++)
    begin
      alarmCase(1'b1, w, 8'h07, 8'h00, 7'h01 << w, 8'h07, 8'h00);
      alarmCase(1'b1, w, 8'h07, 8'h00, 7'h7F ^ (7'h01 << w), 8'h07, 8'h00);
    end
    alarmCase(1'b0, 3'd1, 8'h32, 8'h15, 7'h03, 8'h32, 8'h15);
    alarmCase(1'b0, 3'd5, 8'h25, 8'h30, 7'h26, 8'h25, 8'h30);
    alarmCase(1'b0, 3'd5, 8'h25, 8'h30, 7'h26, 8'h05, 8'h30);
    alarmCase(1'b1, 3'd2, 8'h17, 8'h30, 7'h26, 8'h17, 8'h30);
    alarmCase(1'b1, 3'd6, 8'h22, 8'h5A, 7'h7F, 8'h22, 8'h5A);
    alarmCase(1'b1, 3'd3, 8'h22, 8'h45, 7'h7F, 8'h22, 8'h45);
    alarmCase(1'b1, 3'd4, 8'h24, 8'h10, 7'h7F, 8'h24, 8'h10);
    alarmCase(1'b0, 3'd0, 8'h30, 8'h45, 7'h7F, 8'h30, 8'h45);
    alarmCase(1'b0, 3'd4, 8'h20, 8'h10, 7'h7F, 8'h20, 8'h10);
    apb(1'b1, rtp_pkg::IDX_SUBSEC_TOP, 32'hFF);
    apb(1'b1, rtp_pkg::IDX_PRESCALER_COMPARE, 32'h1);
    apb(1'b1, rtp_pkg::IDX_PRESCALER_MODE, 32'h10);
    apb(1'b0, rtp_pkg::IDX_COUNTER_CONTROL, 32'h0);
    check({31'h0, rd[1]}, 32'h0);
    apb(1'b1, rtp_pkg::IDX_COUNTER_CONTROL, 32'h9);
    apb(1'b0, rtp_pkg::IDX_COUNTER_CONTROL, 32'h0);
    check({31'h0, rd[1]}, 32'h1);
    // Saturday 23:59:59 in 24-hour mode, so the next carry rolls over to Sunday midnight.
    apb(1'b1, rtp_pkg::IDX_CAL_TIME, {5'h0, 8'h59, 8'h59, 8'h23, 3'h6});
    apb(1'b1, rtp_pkg::IDX_COUNTER_CONTROL, 32'h8);
    repeat (20) @(posedge sysClk);
    apb(1'b1, rtp_pkg::IDX_COUNTER_CONTROL, 32'h9);
    apb(1'b0, rtp_pkg::IDX_CAL_TIME, 32'h0);
    check(rd, {5'h0, 8'h59, 8'h59, 8'h23, 3'h6});
    // Frozen for over two seconds on purpose, so a second carry is dropped.
    repeat (1100) @(posedge sysClk);
    apb(1'b0, rtp_pkg::IDX_CAL_TIME, 32'h0);
    check(rd, {5'h0, 8'h59, 8'h59, 8'h23, 3'h6});
    apb(1'b1, rtp_pkg::IDX_COUNTER_CONTROL, 32'h8);
    apb(1'b0, rtp_pkg::IDX_COUNTER_CONTROL, 32'h0);
    check({31'h0, rd[1]}, 32'h0);
    apb(1'b0, rtp_pkg::IDX_CAL_TIME, 32'h0);
    // Exactly one retained carry: Sunday 00:00:00, not one second later.
    check(rd, 32'h0000_0000);
    summarize();
  end
endmodule // testbench
`default_nettype wire
